// ==== logic/btau_core.sv ====
// Purpose: Forms the next program counter of the core for every instruction.
// Assumes: Decoder and memory port run on CLK; CMD is held until accepted.
// Notes:   Table calls stall the decoder until both entry bytes are in.
//
// How it works
// - Without a branch the counter grows by the instruction length.
// - Relative target is next instruction address plus displacement.
// - Displacement is signed, bit 7 sign, reach -128 to +127.
// - Short jump and satisfied conditional branches use relative targets.
// - Full-address call and jump load the 16-bit immediate directly.
// - Fixed-area call builds targets from 11 bits inside 0800H-0FFFH.
// - Table call indexes 0040H-007FH by opcode bits 1-5 and loads it.
// - Register jump copies the accumulator pair into the counter.
`timescale 1ns/1ns
`default_nettype none
module btau_core #(
  parameter logic [15:0] RESET_VALUE = btau_pkg::RESET_PC
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 ARST_N,
  // Decoded instruction handshake
  input  wire logic                 CMD_VALID,
  input  wire btau_pkg::btau_cmd_t  CMD,
  output var  logic                 CMD_READY,
  // Program counter to the fetch unit
  output var  logic [15:0]          PC,
  output var  logic                 PC_UPDATE,
  // Memory read port for vector entries
  output var  logic                 MEM_RD_REQ,
  output var  logic [15:0]          MEM_RD_ADDR,
  input  wire logic                 MEM_RD_VALID,
  input  wire logic [7:0]           MEM_RD_DATA
);

  // Sign extension of an 8-bit displacement.
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[btau_pkg::DISP_SIGN]}}, d};
  endfunction

  // Next sequential address, dropping any carry out of bit 15.
  function automatic logic [15:0] seq_addr(input logic [15:0] pc,
                                           input logic [2:0]  len);
    seq_addr = 16'(pc + {13'h0000, len});
  endfunction

  logic        vec_done;
  logic [15:0] vec_target;

  // Accepted instruction and its target candidates.
  wire logic        accept     = CMD_VALID && CMD_READY;
  wire logic [15:0] next_seq   = seq_addr(PC, CMD.instr_len);
  wire logic [15:0] disp_ext   = sext8(CMD.relative_displacement);
  wire logic [15:0] rel_target = 16'(next_seq + disp_ext);
  wire logic        rel_taken  = !CMD.conditional || CMD.cond_met;
  // short call lands in the fixed area.
  wire logic [15:0] fix_target = btau_pkg::FIXED_AREA_BASE |
                                 {5'h00, CMD.full_target_address[10:0]};
  wire logic [4:0]  tbl_index  =
    CMD.opcode[btau_pkg::TBL_IDX_MSB:btau_pkg::TBL_IDX_LSB];
  wire logic        tbl_start  =
    accept && CMD.mode == btau_pkg::BTAU_TABLE_CALL;

  // Target selection for the accepted instruction.
  logic [15:0] next_pc;
  always_comb begin
    next_pc = next_seq;
    case (CMD.mode)
      btau_pkg::BTAU_SEQUENTIAL: next_pc = next_seq;
      btau_pkg::BTAU_RELATIVE:   next_pc = rel_taken ? rel_target : next_seq;
      btau_pkg::BTAU_FULL_JUMP:  next_pc = CMD.full_target_address;
      btau_pkg::BTAU_FIXED_CALL: next_pc = fix_target;
      btau_pkg::BTAU_PAIR_JUMP:  next_pc = CMD.accumulator_pair;
      default:                   next_pc = PC;
    endcase
  end

  // Program counter and handshake; table calls wait for the fetch.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PC        <= RESET_VALUE;
      PC_UPDATE <= 1'b0;
      CMD_READY <= 1'b1;
    end else begin
      PC_UPDATE <= 1'b0;
      if (vec_done) begin
        PC        <= vec_target;
        PC_UPDATE <= 1'b1;
        CMD_READY <= 1'b1;
      end else if (tbl_start) begin
        CMD_READY <= 1'b0;
      end else if (accept) begin
        PC        <= next_pc;
        PC_UPDATE <= 1'b1;
      end
    end
  end

  btau_vec_fetch u_vec_fetch (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .start    (tbl_start),
    .index    (tbl_index),
    .rd_req   (MEM_RD_REQ),
    .rd_addr  (MEM_RD_ADDR),
    .rd_valid (MEM_RD_VALID),
    .rd_data  (MEM_RD_DATA),
    .done     (vec_done),
    .target   (vec_target)
  );

  // Sequential instructions advance by their length.
  a_seq_advance: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (accept && CMD.mode == btau_pkg::BTAU_SEQUENTIAL) |=>
      (PC_UPDATE && PC == 16'($past(PC) + $past(CMD.instr_len))))
    else $error("Sequential advance wrong.");

  // Taken relative branch lands at next address plus signed displacement.
  a_rel_taken: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (accept && CMD.mode == btau_pkg::BTAU_RELATIVE && rel_taken) |=>
      (PC == 16'($past(PC) + $past(CMD.instr_len)
                 + sext8($past(CMD.relative_displacement)))))
    else $error("Relative target wrong.");

  // The reach stays within -128 to +127 of the next instruction.
  a_rel_reach: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (accept && CMD.mode == btau_pkg::BTAU_RELATIVE && rel_taken) |=>
      ((16'(PC - 16'($past(PC) + $past(CMD.instr_len))) <= 16'h007f) ||
       (16'(PC - 16'($past(PC) + $past(CMD.instr_len))) >= 16'hff80)))
    else $error("Relative reach exceeded.");

  // A failed condition falls through to the next instruction.
  a_rel_untaken: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (accept && CMD.mode == btau_pkg::BTAU_RELATIVE && !rel_taken) |=>
      (PC == 16'($past(PC) + $past(CMD.instr_len))))
    else $error("Untaken branch moved off sequence.");

  // Full-address targets load unchanged.
  a_full_load: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (accept && CMD.mode == btau_pkg::BTAU_FULL_JUMP) |=>
      (PC == $past(CMD.full_target_address)))
    else $error("Full target not loaded.");

  // Fixed-area calls stay inside their window.
  a_fixed_range: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (accept && CMD.mode == btau_pkg::BTAU_FIXED_CALL) |=>
      (PC >= btau_pkg::FIXED_AREA_BASE && PC <= btau_pkg::FIXED_AREA_TOP
       && PC[10:0] == $past(CMD.full_target_address[10:0])))
    else $error("Fixed-area call out of window.");

  // Table call reads the even entry address inside the table next cycle.
  a_table_addr: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    tbl_start |=> (MEM_RD_REQ && !CMD_READY && !MEM_RD_ADDR[0]
      && MEM_RD_ADDR >= btau_pkg::TABLE_BASE
      && MEM_RD_ADDR <= btau_pkg::TABLE_TOP
      && MEM_RD_ADDR[5:1] == $past(tbl_index)))
    else $error("Vector table address wrong.");

  // The fetched entry becomes the counter one cycle after it arrives.
  a_table_load: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    vec_done |=> (PC == $past(vec_target) && PC_UPDATE && CMD_READY))
    else $error("Vector entry not loaded.");

  // Register jump takes the accumulator pair.
  a_pair_copy: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (accept && CMD.mode == btau_pkg::BTAU_PAIR_JUMP) |=>
      (PC == $past(CMD.accumulator_pair) && PC_UPDATE))
    else $error("Accumulator pair not copied.");

endmodule
`default_nettype wire

// ==== logic/btau_pkg.sv ====
// Purpose: Shared types and constants of the branch target address unit.
// Assumes: A 16-bit program address space and byte-wide program memory.
// Notes:   Every address constant used by the logic is named here.
`default_nettype none
package btau_pkg;

  // Address and field widths.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned LEN_W  = 3;
  localparam int unsigned IDX_W  = 5;

  // Program counter value after reset.
  localparam logic [15:0] RESET_PC        = 16'h0000;
  // Window reached by the fixed-area call.
  localparam logic [15:0] FIXED_AREA_BASE = 16'h0800;
  localparam logic [15:0] FIXED_AREA_TOP  = 16'h0fff;
  localparam int unsigned SHORT_W         = 11;
  // Vector table bounds.
  localparam logic [15:0] TABLE_BASE      = 16'h0040;
  localparam logic [15:0] TABLE_TOP       = 16'h007f;
  // Opcode bits that pick the vector table entry.
  localparam int unsigned TBL_IDX_LSB     = 1;
  localparam int unsigned TBL_IDX_MSB     = 5;
  // Sign bit of the relative displacement.
  localparam int unsigned DISP_SIGN       = 7;

  // Target source of one instruction.
  typedef enum logic [2:0] {
    BTAU_SEQUENTIAL,
    BTAU_RELATIVE,
    BTAU_FULL_JUMP,
    BTAU_FIXED_CALL,
    BTAU_TABLE_CALL,
    BTAU_PAIR_JUMP
  } btau_mode_t;

  // One decoded instruction as handed over by the decoder.
  typedef struct packed {
    btau_mode_t         mode;
    logic [LEN_W-1:0]   instr_len;             // Bytes of this instruction.
    logic               conditional;           // Relative branch has a test.
    logic               cond_met;              // Test outcome.
    logic [7:0]         relative_displacement;
    logic [15:0]        full_target_address;   // Low 11 bits: short call.
    logic [7:0]         opcode;
    logic [15:0]        accumulator_pair;
  } btau_cmd_t;

endpackage
`default_nettype wire

// ==== logic/btau_vec_fetch.sv ====
// Purpose: Reads one two-byte vector table entry over the memory read port.
// Assumes: Each read is answered by one rd_valid pulse while rd_req is high.
// Notes:   Low byte is read from the even address, then the high byte.
`timescale 1ns/1ns
`default_nettype none
module btau_vec_fetch (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Request from the core
  input  wire logic        start,
  input  wire logic [4:0]  index,
  // Memory read port
  output var  logic        rd_req,
  output var  logic [15:0] rd_addr,
  input  wire logic        rd_valid,
  input  wire logic [7:0]  rd_data,
  // Result
  output var  logic        done,
  output var  logic [15:0] target
);

  typedef enum logic [1:0] {VF_IDLE, VF_LOW, VF_HIGH} btau_vf_state_t;

  btau_vf_state_t state;
  logic [7:0]     low_byte;

  // Entry address is the table base plus twice the index.
  wire logic [15:0] entry_addr = btau_pkg::TABLE_BASE | {10'h000, index, 1'b0};

  // Two-read sequence: even address first, then the odd one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= VF_IDLE;
      rd_req   <= 1'b0;
      rd_addr  <= 16'h0000;
      low_byte <= 8'h00;
      done     <= 1'b0;
      target   <= 16'h0000;
    end else begin
      done <= 1'b0;
      case (state)
        VF_IDLE: begin
          if (start) begin
            rd_req  <= 1'b1;
            rd_addr <= entry_addr;
            state   <= VF_LOW;
          end
        end
        VF_LOW: begin
          if (rd_valid) begin
            low_byte <= rd_data;
            rd_addr  <= rd_addr | 16'h0001;
            state    <= VF_HIGH;
          end
        end
        VF_HIGH: begin
          if (rd_valid) begin
            rd_req <= 1'b0;
            target <= {rd_data, low_byte};
            done   <= 1'b1;
            state  <= VF_IDLE;
          end
        end
        default: state <= VF_IDLE;
      endcase
    end
  end

  // The high byte read uses the odd address and lands in the top half.
  a_vec_byte_pair: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == VF_HIGH && rd_valid) |=>
      (done && target[15:8] == $past(rd_data) && $past(rd_addr[0])
       && target[7:0] == $past(low_byte)))
    else $error("Vector entry bytes paired wrongly.");

endmodule
`default_nettype wire

// ==== bench/btau_mem_model.sv ====
// Purpose: Program memory model that answers vector entry reads.
// Assumes: One read is outstanding at a time; request held until answered.
// Notes:   Between answers the data line toggles so stale bytes never match.
`timescale 1ns/1ns
`default_nettype none
module btau_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Read port
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output var  logic        rd_valid,
  output var  logic [7:0]  rd_data,
  // Answer speed select
  input  wire logic        slow
);
  logic [1:0] wait_cnt;

  // Answers after zero or three idle cycles and scrambles data otherwise.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      wait_cnt <= 2'h0;
    end else if (rd_req && !rd_valid && wait_cnt == 2'h0) begin
      rd_valid <= 1'b1;
      rd_data  <= rd_addr[7:0] ^ 8'h5c; // Content tied to the byte address.
    end else begin
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data;
      wait_cnt <= (rd_req && !rd_valid) ? wait_cnt - 2'h1 : {slow, slow};
    end
  end
endmodule
`default_nettype wire

// ==== bench/branch_target_address_unit_tb.sv ====
// Purpose: Self-checking bench of the branch target address unit.
// Assumes: One instruction is offered at a time and held until taken.
// Notes:   Random modes with fixed corner cases in the first iterations.
`timescale 1ns/1ns
`default_nettype none
module branch_target_address_unit_tb;
  logic                clk;
  logic                arst_n;
  logic                cmd_valid;
  btau_pkg::btau_cmd_t cmd;
  logic                cmd_ready;
  logic [15:0]         pc;
  logic                pc_update;
  logic                rd_req;
  logic [15:0]         rd_addr;
  logic                rd_valid;
  logic [7:0]          rd_data;
  logic                slow;
  logic [31:0]         seed;
  logic [15:0]         model_pc;
  int                  mismatches;
  int                  num_checks;

  btau_core btau_core_inst (
    .CLK(clk), .ARST_N(arst_n), .CMD_VALID(cmd_valid), .CMD(cmd),
    .CMD_READY(cmd_ready), .PC(pc), .PC_UPDATE(pc_update),
    .MEM_RD_REQ(rd_req), .MEM_RD_ADDR(rd_addr),
    .MEM_RD_VALID(rd_valid), .MEM_RD_DATA(rd_data));
  btau_mem_model btau_mem_model_inst (
    .clk(clk), .arst_n(arst_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .slow(slow));

  // Clock of 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Steps the xorshift generator.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Works out the counter after one instruction.
  function automatic logic [15:0] exp_pc(input logic [15:0] p,
                                         input btau_pkg::btau_cmd_t c);
    logic [15:0] nxt;
    logic [7:0]  lo;
    nxt = p + {13'h0000, c.instr_len};
    lo  = 8'h40 | {2'h0, c.opcode[5:1], 1'b0};
    case (c.mode)
      btau_pkg::BTAU_SEQUENTIAL: return nxt;
      btau_pkg::BTAU_RELATIVE:
        return (!c.conditional || c.cond_met) ?
          nxt + {{8{c.relative_displacement[7]}}, c.relative_displacement} :
          nxt;
      btau_pkg::BTAU_FULL_JUMP:  return c.full_target_address;
      btau_pkg::BTAU_FIXED_CALL:
        return 16'h0800 | {5'h00, c.full_target_address[10:0]};
      btau_pkg::BTAU_TABLE_CALL:
        return {(lo | 8'h01) ^ 8'h5c, lo ^ 8'h5c};
      btau_pkg::BTAU_PAIR_JUMP:  return c.accumulator_pair;
      default:                   return p;
    endcase
  endfunction

  // Compares one value and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Holds reset for ten cycles and checks the reset state.
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    model_pc = btau_pkg::RESET_PC;
    @(negedge clk);
    chk(pc, model_pc);
    chk({15'h0000, cmd_ready}, 16'h0001);
  endtask

  // Offers one instruction, waits for the load and checks the counter.
  task automatic send(input btau_pkg::btau_cmd_t c);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= c;
    slow      <= seed[9];
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 60);
    cmd_valid <= 1'b0;
    cmd       <= ~c;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pc_update !== 1'b1 && n < 60);
    model_pc = exp_pc(model_pc, c);
    chk({15'h0000, pc_update}, 16'h0001);
    chk(pc, model_pc);
  endtask

  // Watchdog that cuts a hang short.
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // Main sequence: random instructions with corner cases first.
  initial begin
    btau_pkg::btau_cmd_t c;
    arst_n     = 1'b0;
    cmd_valid  = 1'b0;
    cmd        = '0;
    slow       = 1'b0;
    seed       = 32'h9cbf34a3;
    mismatches = 0;
    num_checks = 0;
    do_reset();
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      c = seed ^ {xs(seed), xs(~seed), xs(seed ^ 32'h1234abcd)};
      c.mode = btau_pkg::btau_mode_t'(seed[2:0]);
      c.instr_len = {1'b0, seed[4:3]} + 3'h1;
      case (i)
        0: {c.mode, c.conditional, c.relative_displacement} =
             {btau_pkg::BTAU_RELATIVE, 1'b0, 8'h80};
        1: {c.mode, c.full_target_address} =
             {btau_pkg::BTAU_FULL_JUMP, 16'hfffe};
        2: {c.mode, c.conditional, c.cond_met, c.relative_displacement} =
             {btau_pkg::BTAU_RELATIVE, 2'b11, 8'h7f};
        3: {c.mode, c.conditional, c.cond_met} =
             {btau_pkg::BTAU_RELATIVE, 2'b10};
        4: {c.mode, c.opcode} = {btau_pkg::BTAU_TABLE_CALL, 8'h00};
        5: {c.mode, c.opcode} = {btau_pkg::BTAU_TABLE_CALL, 8'hff};
        6: {c.mode, c.full_target_address} =
             {btau_pkg::BTAU_FIXED_CALL, 16'hffff};
        200: do_reset();
        default: ;
      endcase
      send(c);
    end
    end_sim();
  end
endmodule
`default_nettype wire
